/* File: rtl/pcielc_link_ctl.sv */
// Purpose: per-port link control register with apb access
// Assumes: switch unlock bit and ltssm status arrive on clk_sys
// Notes:   zero-wait apb: pready rises one cycle after setup
//
// The APB slave port was decided locally.
`default_nettype none
module pcielc_link_ctl
#(
    parameter bit UPSTREAM_PORT = 1'b0
)
(
    // clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         reset_n,
    // apb slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [11:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,
    output var  logic                         pready,
    output var  logic [31:0]                  prdata,
    output var  logic                         pslverr,
    // switch level and eeprom
    input  wire logic                         registerUnlockBit,
    input  wire pcielc_pkg::pcielc_eeprom_type eepromLoad,
    // physical layer
    input  wire logic                         ltssmTraining,
    output var  pcielc_pkg::pcielc_ctl_type   ctlOut,
    output var  logic                         retrainReq
);
    import pcielc_pkg::*;

    logic        linkDisableBit_r;
    logic        trainingStatus;
    logic        setupPhase;
    logic        writeTaken;
    logic        hitCtl;
    logic        hitSts;
    logic        retrainAllowed;
    logic        retrainWrite;
    logic [15:0] ctlView;
    logic [15:0] stsView;

    // elaboration check on the port kind
    if (UPSTREAM_PORT !== 1'b0 && UPSTREAM_PORT !== 1'b1)
    begin : g_badParam
        $error("UPSTREAM_PORT must be 0 or 1");
    end

    // apb decode
    assign setupPhase = psel & ~penable;
    assign writeTaken = psel & penable & pready & pwrite;
    assign hitCtl     = (paddr == LINK_CTL_ADDR);
    assign hitSts     = (paddr == LINK_STS_ADDR);

    // retrain permission: upstream needs the switch unlock
    assign retrainAllowed = !UPSTREAM_PORT || registerUnlockBit;
    assign retrainWrite   = writeTaken & hitCtl & pstrb[0] & pwdata[RETRAIN_POS]
                          & retrainAllowed;

    // readback image; fixed and reserved bits are zero
    always_comb
    begin
        ctlView = 16'h0000;
        ctlView[ASPM_HI_POS:ASPM_LO_POS] = {ctlOut.aspmL1Enable, ctlOut.aspmL0sEnable};
        ctlView[LINK_DISABLE_BIT_POS]  = linkDisableBit_r;
        ctlView[COMMON_REFCLOCK_FLAG_POS]  = ctlOut.commonClock;
        ctlView[EXTENDED_SYNC_ENABLE_POS] = ctlOut.extendedSync;
        stsView = 16'h0000;
        stsView[TRAINING_POS] = trainingStatus;
    end

    // pready for one access cycle after each setup
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            pready <= 1'b0;
        else
            pready <= setupPhase;
    end

    // read data and error latched in the setup cycle
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            prdata  <= RDATA_RESET;
            pslverr <= 1'b0;
        end
        else if (setupPhase)
        begin
            pslverr <= ~(hitCtl | hitSts);
            if (pwrite)
                prdata <= RDATA_RESET;
            else if (hitCtl)
                prdata <= {16'h0000, ctlView};
            else if (hitSts)
                prdata <= {16'h0000, stsView};
            else
                prdata <= RDATA_RESET;
        end
    end

    // aspm field: software write, else eeprom override
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            ctlOut.aspmL0sEnable <= ASPM_RESET[0];
            ctlOut.aspmL1Enable  <= ASPM_RESET[1];
        end
        else if (writeTaken && hitCtl && pstrb[0])
        begin
            ctlOut.aspmL0sEnable <= pwdata[ASPM_LO_POS];
            ctlOut.aspmL1Enable  <= pwdata[ASPM_HI_POS];
        end
        else if (eepromLoad.valid)
        begin
            ctlOut.aspmL0sEnable <= eepromLoad.aspm[0];
            ctlOut.aspmL1Enable  <= eepromLoad.aspm[1];
        end
    end

    // link disable, common clock and extended sync bits
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            linkDisableBit_r     <= CTL_BIT_RESET;
            ctlOut.linkDisable   <= CTL_BIT_RESET;
            ctlOut.commonClock   <= CTL_BIT_RESET;
            ctlOut.extendedSync  <= CTL_BIT_RESET;
        end
        else if (writeTaken && hitCtl && pstrb[0])
        begin
            linkDisableBit_r     <= pwdata[LINK_DISABLE_BIT_POS];
            ctlOut.linkDisable   <= pwdata[LINK_DISABLE_BIT_POS] & ~UPSTREAM_PORT;
            ctlOut.commonClock   <= pwdata[COMMON_REFCLOCK_FLAG_POS];
            ctlOut.extendedSync  <= pwdata[EXTENDED_SYNC_ENABLE_POS];
        end
    end

    // retrain pulse leaves with the fields of the same write
    pcielc_retrain u_retrain
    (
        .clk_sys          (clk_sys),
        .reset_n          (reset_n),
        .retrainWrite     (retrainWrite),
        .ltssmTraining    (ltssmTraining),
        .retrainPulse_r   (retrainReq),
        .trainingStatus_r (trainingStatus)
    );

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    property p_aspmWrite;
        writeTaken && hitCtl && pstrb[0] |=>
            {ctlOut.aspmL1Enable, ctlOut.aspmL0sEnable} == $past(pwdata[1:0]);
    endproperty
    a_aspmWrite: assert property (p_aspmWrite)
        else $error("aspm field did not take written value");

    property p_resetClear;
        !$past(reset_n) |-> ctlOut == '0 && !retrainReq && !linkDisableBit_r;
    endproperty
    a_resetClear: assert property (p_resetClear)
        else $error("control not cleared by reset");

    property p_fixedZero;
        pready && !pwrite && hitCtl |->
            prdata[RCB_POS] == 1'b0 && prdata[RETRAIN_POS] == 1'b0
            && prdata[CLKPM_POS] == 1'b0 && prdata[RSVD2_POS] == 1'b0
            && prdata[31:9] == '0;
    endproperty
    a_fixedZero: assert property (p_fixedZero)
        else $error("fixed control bit read nonzero");

    property p_linkDisable;
        writeTaken && hitCtl && pstrb[0] |=>
            ctlOut.linkDisable == ($past(pwdata[LINK_DISABLE_BIT_POS]) && !UPSTREAM_PORT);
    endproperty
    a_linkDisable: assert property (p_linkDisable)
        else $error("link disable output wrong for port kind");

    property p_retrainStart;
        writeTaken && hitCtl && pstrb[0] && pwdata[RETRAIN_POS] && retrainAllowed
            |=> retrainReq ##1 !retrainReq;
    endproperty
    a_retrainStart: assert property (p_retrainStart)
        else $error("retrain write gave no single pulse");

    property p_retrainLocked;
        retrainReq |-> $past(retrainAllowed) && $past(writeTaken);
    endproperty
    a_retrainLocked: assert property (p_retrainLocked)
        else $error("retrain pulse without permitted write");

    property p_applyTogether;
        retrainReq |-> ctlOut.extendedSync == $past(pwdata[EXTENDED_SYNC_ENABLE_POS])
            && ctlOut.commonClock == $past(pwdata[COMMON_REFCLOCK_FLAG_POS]);
    endproperty
    a_applyTogether: assert property (p_applyTogether)
        else $error("fields lag the retrain they belong to");

    property p_syncHold;
        !(writeTaken && hitCtl && pstrb[0]) |=> $stable(ctlOut.extendedSync)
            && $stable(ctlOut.commonClock);
    endproperty
    a_syncHold: assert property (p_syncHold)
        else $error("extended sync or common clock changed without write");

    property p_training;
        retrainReq |-> trainingStatus;
    endproperty
    a_training: assert property (p_training)
        else $error("training status low during retrain request");
endmodule
`default_nettype wire

/* File: rtl/pcielc_pkg.sv */
// Purpose: shared constants and carrier types for the port link control block
// Assumes: 32-bit APB, byte addresses, 100 MHz core clock
// Notes:   field positions and reset values live here only
`default_nettype none
package pcielc_pkg;
    // register byte addresses
    localparam logic [11:0] LINK_CTL_ADDR    = 12'h050;
    localparam logic [11:0] LINK_STS_ADDR    = 12'h060;
    // control field positions
    localparam int ASPM_LO_POS   = 0;
    localparam int ASPM_HI_POS   = 1;
    localparam int RSVD2_POS     = 2;
    localparam int RCB_POS       = 3;
    localparam int LINK_DISABLE_BIT_POS      = 4;
    localparam int RETRAIN_POS   = 5;
    localparam int COMMON_REFCLOCK_FLAG_POS      = 6;
    localparam int EXTENDED_SYNC_ENABLE_POS     = 7;
    localparam int CLKPM_POS     = 8;
    // status field position
    localparam int TRAINING_POS  = 11;
    // reset values
    localparam logic [1:0]  ASPM_RESET       = 2'h0;
    localparam logic        CTL_BIT_RESET    = 1'h0;
    localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;
    // aspm field encodings
    localparam logic [1:0]  ASPM_DISABLED    = 2'h0;
    localparam logic [1:0]  ASPM_L0S         = 2'h1;
    localparam logic [1:0]  ASPM_L1          = 2'h2;
    localparam logic [1:0]  ASPM_L0S_L1      = 2'h3;

    // control levels handed to the physical layer
    typedef struct packed {
        logic aspmL0sEnable;
        logic aspmL1Enable;
        logic linkDisable;
        logic commonClock;
        logic extendedSync;
    } pcielc_ctl_type;

    // serial eeprom override of the aspm field
    typedef struct packed {
        logic       valid;
        logic [1:0] aspm;
    } pcielc_eeprom_type;
endpackage
`default_nettype wire

/* File: rtl/pcielc_retrain.sv */
// Purpose: retrain request pulse and training-in-progress tracking
// Assumes: ltssm training level is on clk_sys
// Notes:   pending holds from the request until the ltssm reports training
`default_nettype none
module pcielc_retrain
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // request from register write
    input  wire logic retrainWrite,
    // physical layer
    input  wire logic ltssmTraining,
    output var  logic retrainPulse_r,
    output var  logic trainingStatus_r
);
    logic pending_r;

    // one-cycle request to steer the ltssm into recovery
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            retrainPulse_r <= 1'b0;
        else
            retrainPulse_r <= retrainWrite;
    end

    // pending until training seen; a new request wins over the clear
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            pending_r <= 1'b0;
        else if (retrainWrite)
            pending_r <= 1'b1;
        else if (ltssmTraining)
            pending_r <= 1'b0;
    end

    // status covers the request gap and the ltssm training itself
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            trainingStatus_r <= 1'b0;
        else
            trainingStatus_r <= retrainWrite | pending_r | ltssmTraining;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    property p_statusHolds;
        retrainPulse_r && !ltssmTraining |=> trainingStatus_r;
    endproperty
    a_statusHolds: assert property (p_statusHolds)
        else $error("training status dropped before training began");
endmodule
`default_nettype wire

/* File: verif/pcielc_link_ctl_bench.sv */
// Purpose: self-checking bench for the port link control register
// Assumes: one downstream and one upstream instance share the apb wires
// Notes:   each port has its own select; outputs sampled at rising edges
`default_nettype none
module pcielc_link_ctl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import pcielc_pkg::*;

    logic              clk_sys = 1'b0;
    logic              reset_n = 1'b0;
    logic              selD = 1'b0, selU = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]       paddr = 12'h000;
    logic [31:0]       pwdata = 32'h0000_0000;
    logic [3:0]        pstrb = 4'hf;
    logic              unlock = 1'b0, ltssm = 1'b0;
    pcielc_eeprom_type eeprom = '0;
    logic              readyD, readyU, errD, errU, pulseD, pulseU;
    logic [31:0]       rdataD, rdataU, rdat;
    pcielc_ctl_type    ctlD, ctlU;
    int                badCount = 0, checked = 0;

    // core clock, 10 ns period
    always #5 clk_sys = ~clk_sys;

    pcielc_link_ctl #(.UPSTREAM_PORT(1'b0)) pcielc_link_ctl_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .psel(selD), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(readyD), .prdata(rdataD), .pslverr(errD),
        .registerUnlockBit(unlock), .eepromLoad(eeprom), .ltssmTraining(ltssm),
        .ctlOut(ctlD), .retrainReq(pulseD));
    pcielc_link_ctl #(.UPSTREAM_PORT(1'b1)) pcielc_link_ctl_up_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .psel(selU), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(readyU), .prdata(rdataU), .pslverr(errU),
        .registerUnlockBit(unlock), .eepromLoad(eeprom), .ltssmTraining(ltssm),
        .ctlOut(ctlU), .retrainReq(pulseU));

    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            badCount++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // one apb transfer; pready, read data and slverr taken at the same rising edge
    task automatic xfer(input bit up, input bit wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        selD <= !up;
        selU <= up;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while ((up ? readyU : readyD) !== 1'b1 && n < 20)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 20)
        begin
            chk(32'h1, 32'h0, "pready timeout");
            wrap_up();
        end
        else
        begin
            rdat = up ? rdataU : rdataD;
            chk({31'h0, up ? errU : errD},
                {31'h0, a != LINK_CTL_ADDR && a != LINK_STS_ADDR}, "slverr");
            selD <= 1'b0;
            selU <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // watchdog
    initial
    begin
        #200000;
        chk(32'h1, 32'h0, "run timeout");
        wrap_up();
    end

    // main sequence
    initial
    begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        xfer(0, 0, LINK_CTL_ADDR, 32'h0);
        chk(rdat, 32'h0, "control reset");
        xfer(0, 0, LINK_STS_ADDR, 32'h0);
        chk(rdat, 32'h0, "status reset");
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            xfer(0, 1, LINK_CTL_ADDR, 32'(i));
            @(posedge clk_sys);
            chk({27'h0, ctlD}, {27'h0, i[0], i[1], 3'b000}, "aspm levels");
            xfer(0, 0, LINK_CTL_ADDR, 32'h0);
            chk(rdat, 32'(i), "aspm readback");
        end
        $display("test aspm done");
        xfer(0, 1, LINK_CTL_ADDR, 32'hffff_ffff);
        @(posedge clk_sys);
        chk({31'h0, pulseD}, 32'h1, "retrain pulse");
        chk({27'h0, ctlD}, 32'h1f, "levels at retrain");
        @(posedge clk_sys);
        chk({31'h0, pulseD}, 32'h0, "pulse one cycle");
        xfer(0, 0, LINK_CTL_ADDR, 32'h0);
        chk(rdat, 32'h0000_00d3, "fixed bits");
        chk({31'h0, pulseD}, 32'h0, "pulse ended");
        xfer(0, 0, LINK_STS_ADDR, 32'h0);
        chk(rdat, 32'h0000_0800, "training pending");
        @(posedge clk_sys);
        ltssm <= 1'b1;
        repeat (3) @(posedge clk_sys);
        xfer(0, 0, LINK_STS_ADDR, 32'h0);
        chk(rdat, 32'h0000_0800, "training running");
        ltssm <= 1'b0;
        repeat (3) @(posedge clk_sys);
        xfer(0, 0, LINK_STS_ADDR, 32'h0);
        chk(rdat, 32'h0, "training over");
        $display("test downstream retrain done");
        xfer(1, 1, LINK_CTL_ADDR, 32'hffff_ffff);
        @(posedge clk_sys);
        chk({31'h0, pulseU}, 32'h0, "locked retrain");
        chk({27'h0, ctlU}, 32'h1b, "upstream levels");
        xfer(1, 0, LINK_CTL_ADDR, 32'h0);
        chk(rdat, 32'h0000_00d3, "upstream readback");
        @(posedge clk_sys);
        unlock <= 1'b1;
        xfer(1, 1, LINK_CTL_ADDR, 32'h0000_0020);
        @(posedge clk_sys);
        chk({31'h0, pulseU}, 32'h1, "unlocked retrain");
        $display("test upstream done");
        @(posedge clk_sys);
        eeprom <= '{valid: 1'b1, aspm: ASPM_L1};
        @(posedge clk_sys);
        eeprom <= '0;
        @(posedge clk_sys);
        chk({27'h0, ctlD}, 32'h0f, "eeprom aspm");
        xfer(0, 1, 12'h070, 32'h0000_0003);
        xfer(0, 0, 12'h070, 32'h0);
        chk(rdat, 32'h0, "unmapped read");
        // a write without lane 0 strobe must leave the register alone
        pstrb <= 4'he;
        xfer(0, 1, LINK_CTL_ADDR, 32'h0000_0000);
        pstrb <= 4'hf;
        xfer(0, 0, LINK_CTL_ADDR, 32'h0);
        chk(rdat, 32'h0000_00d2, "after unmapped write");
        $display("test eeprom and unmapped done");
        wrap_up();
    end
endmodule
`default_nettype wire
